// ### i2c_master_sequencer.v
/*
 * Master mode transfer sequencer of a multimaster I2C interface: start,
 * 7- and 10-bit address, byte handshakes with SCL stretching, stop,
 * error cases and the shared interrupt request.
 * Assumes register accesses arrive as one-cycle strobes on sys_clk_i
 * and that SCL and SDA are open-drain lines with external pull-ups.
 */
`timescale 1ns/100ps
`include "i2c_seq_map.vh"

module i2c_master_sequencer (
	input  wire       sys_clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	input  wire       halt_i,
	input  wire       global_mask_i,
	input  wire       periph_enable_i,
	input  wire       ack_enable_i,
	input  wire       irq_enable_i,
	input  wire       fast_mode_i,
	input  wire       start_set_i,
	input  wire       stop_set_i,
	input  wire       stop_clr_i,
	input  wire       rd_sr1_i,
	input  wire       rd_sr2_i,
	input  wire       rd_dr_i,
	input  wire       wr_dr_i,
	input  wire       wr_cr_i,
	input  wire [7:0] wr_data_i,
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       scl_o,
	output wire       scl_oe_n_o,
	output wire       sda_o,
	output wire       sda_oe_n_o,
	output reg  [7:0] data_o,
	output reg        start_req_o,
	output reg        stop_req_o,
	output wire       event_flag_o,
	output reg        header_sent_flag_o,
	output reg        byte_done_flag_o,
	output reg        transmit_flag_o,
	output reg        busy_flag_o,
	output reg        master_select_flag_o,
	output reg        start_sent_flag_o,
	output reg        nack_flag_o,
	output reg        stop_seen_flag_o,
	output reg        arb_lost_flag_o,
	output reg        bus_error_flag_o,
	output wire       irq_o
);

	// ------------------------------------------------------------------
	// States and hold reasons
	// ------------------------------------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_START = 3'h1;
	localparam [2:0] S_HOLD  = 3'h2;
	localparam [2:0] S_BIT   = 3'h3;
	localparam [2:0] S_STOP  = 3'h4;
	localparam [2:0] S_FREE  = 3'h5;

	localparam [2:0] H_SB    = 3'h0;
	localparam [2:0] H_HEADER_SENT_FLAG = 3'h1;
	localparam [2:0] H_ADDR  = 3'h2;
	localparam [2:0] H_TX    = 3'h3;
	localparam [2:0] H_RX    = 3'h4;

	reg  [2:0] state;
	reg  [2:0] hold;
	reg  [1:0] phase;
	reg  [3:0] bit_idx;
	reg  [7:0] shift;
	reg        is_addr;
	reg        is_hdr;
	reg        rx_dir;
	reg        addr_done;
	reg        sr1_seen;
	reg        scl_drv;
	reg        sda_drv;
	reg        stop_prev;
	reg        no_stop_evt;

	wire run;
	wire scl_s;
	wire sda_s;
	wire start_det;
	wire stop_det;
	wire tick;
	wire timer_idle;
	wire rx_byte;
	wire ack_slot;
	wire hi_wait;
	wire step;
	wire last_q;
	wire hdr_wr;

	// Halt freezes every flop; the clock enable does the same.
	assign run = ce_i & ~halt_i;
	assign timer_idle = (state == S_IDLE) | (state == S_HOLD) |
	                    (state == S_FREE);

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	i2c_line_monitor u_mon (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.en_i        (run),
		.scl_i       (scl_i),
		.sda_i       (sda_i),
		.scl_o       (scl_s),
		.sda_o       (sda_s),
		.start_det_o (start_det),
		.stop_det_o  (stop_det)
	);

	i2c_bit_timer u_tmr (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.en_i      (run),
		.restart_i (timer_idle),
		.fast_i    (fast_mode_i),
		.tick_o    (tick)
	);

	// ------------------------------------------------------------------
	// Bit phase helpers
	// ------------------------------------------------------------------
	// Phase 2 waits for SCL really high, so a slave may stretch it.
	assign hi_wait  = (phase == 2'h2) & ~scl_s;
	assign step     = tick & ~hi_wait;
	assign last_q   = step & (phase == 2'h3);
	assign ack_slot = (bit_idx == `I2C_ACK_IDX);
	assign rx_byte  = rx_dir & ~is_addr;
	assign hdr_wr   = (wr_data_i[7:3] == `I2C_HDR_PATTERN);

	// ------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------
	// Open drain: output value is always low, enable low while pulling.
	// In halt the lines are let go, so no bus traffic is acknowledged.
	assign scl_o      = 1'b0;
	assign sda_o      = 1'b0;
	assign scl_oe_n_o = ~(scl_drv & ~halt_i);
	assign sda_oe_n_o = ~(sda_drv & ~halt_i);

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	// Every event ORs into one flag and one level request, so the line
	// stays high until the last pending flag has been cleared.
	assign event_flag_o = start_sent_flag_o | header_sent_flag_o |
	                      byte_done_flag_o | nack_flag_o |
	                      arb_lost_flag_o | bus_error_flag_o |
	                      stop_seen_flag_o | addr_done;
	// The request also wakes the processor from wait; in halt no flag can
	// change, but a pending flag still drives it, as halt_i does not gate it.
	assign irq_o = event_flag_o & irq_enable_i &
	               ~global_mask_i;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// One process holds the state machine and all flags so each flag
	// has a single owner; sets are written after clears so a set in the
	// same cycle as its clear wins, except for busy and the start and stop requests.
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			state                <= S_IDLE;
			hold                 <= H_SB;
			phase                <= 2'h0;
			bit_idx              <= 4'h0;
			shift                <= 8'h00;
			is_addr              <= 1'b0;
			is_hdr               <= 1'b0;
			rx_dir               <= 1'b0;
			addr_done            <= 1'b0;
			sr1_seen             <= 1'b0;
			scl_drv              <= 1'b0;
			sda_drv              <= 1'b0;
			stop_prev            <= 1'b0;
			no_stop_evt          <= 1'b0;
			data_o               <= 8'h00;
			start_req_o          <= 1'b0;
			stop_req_o           <= 1'b0;
			header_sent_flag_o   <= 1'b0;
			byte_done_flag_o     <= 1'b0;
			transmit_flag_o      <= 1'b0;
			busy_flag_o          <= 1'b0;
			master_select_flag_o <= 1'b0;
			start_sent_flag_o    <= 1'b0;
			nack_flag_o          <= 1'b0;
			stop_seen_flag_o     <= 1'b0;
			arb_lost_flag_o      <= 1'b0;
			bus_error_flag_o     <= 1'b0;
		end else if (run) begin
			// Stop request is software owned, kept while disabled.
			if (stop_set_i)
				stop_req_o <= 1'b1;
			if (stop_clr_i)
				stop_req_o <= 1'b0;
			stop_prev <= stop_req_o;

			// Bus busy tracks conditions even without the peripheral.
			if (start_det)
				busy_flag_o <= 1'b1;
			if (stop_det)
				busy_flag_o <= 1'b0;

			if (!periph_enable_i) begin
				// Disabled: control and status drop except stop request and busy, lines released.
				state                <= S_IDLE;
				scl_drv              <= 1'b0;
				sda_drv              <= 1'b0;
				sr1_seen             <= 1'b0;
				addr_done            <= 1'b0;
				no_stop_evt          <= 1'b0;
				start_req_o          <= 1'b0;
				header_sent_flag_o   <= 1'b0;
				byte_done_flag_o     <= 1'b0;
				transmit_flag_o      <= 1'b0;
				master_select_flag_o <= 1'b0;
				start_sent_flag_o    <= 1'b0;
				nack_flag_o          <= 1'b0;
				stop_seen_flag_o     <= 1'b0;
				arb_lost_flag_o      <= 1'b0;
				bus_error_flag_o     <= 1'b0;
			end else begin
				if (start_set_i)
					start_req_o <= 1'b1;
				if (rd_sr1_i && event_flag_o)
					sr1_seen <= 1'b1;

				// Error flags clear on a status two read.
				if (rd_sr2_i) begin
					nack_flag_o      <= 1'b0;
					stop_seen_flag_o <= 1'b0;
					arb_lost_flag_o  <= 1'b0;
					bus_error_flag_o <= 1'b0;
				end

				// Slave side release after a nack: status one read drops
				// nack, a stop pulse or an all-ones write drops byte done.
				if (!master_select_flag_o) begin
					if (rd_sr1_i)
						nack_flag_o <= 1'b0;
					if (byte_done_flag_o && stop_prev && !stop_req_o) begin
						byte_done_flag_o <= 1'b0;
						transmit_flag_o  <= 1'b0;
						no_stop_evt      <= 1'b1;
					end
					if (wr_dr_i && wr_data_i == 8'hFF) begin
						byte_done_flag_o <= 1'b0;
						transmit_flag_o  <= 1'b0;
					end
				end

				// A Stop seen as slave raises its event unless the lines
				// were released by a stop pulse beforehand.
				if (stop_det) begin
					no_stop_evt     <= 1'b0;
					transmit_flag_o <= 1'b0;
					if (!master_select_flag_o && !no_stop_evt)
						stop_seen_flag_o <= 1'b1;
				end

				case (state)
				S_IDLE: begin
					scl_drv <= 1'b0;
					sda_drv <= 1'b0;
					// Start only on a free bus; a busy bus keeps it pending.
					if (start_req_o && !busy_flag_o) begin
						master_select_flag_o <= 1'b1;
						state                <= S_START;
						phase                <= 2'h0;
					end
				end

				S_START: begin
					if (step) begin
						phase <= phase + 2'h1;
						case (phase)
						2'h0: begin
							sda_drv <= 1'b0;
						end
						2'h1: begin
							scl_drv <= 1'b0;
						end
						2'h2: begin
							sda_drv <= 1'b1;
						end
						default: begin
							// Start is on the bus: flag it and hold SCL.
							scl_drv           <= 1'b1;
							start_req_o       <= 1'b0;
							start_sent_flag_o <= 1'b1;
							sr1_seen          <= 1'b0;
							hold              <= H_SB;
							state             <= S_HOLD;
						end
						endcase
					end else if (phase == 2'h0) begin
						scl_drv <= 1'b1;
					end
				end

				S_HOLD: begin
					scl_drv <= 1'b1;
					// Repeated start ends any hold but the start hold; stop ends a transmit hold, or a receive hold on a data read.
					if (start_req_o && hold != H_SB) begin
						state <= S_START;
						phase <= 2'h0;
					end else if (stop_req_o && (hold == H_TX ||
					             (hold == H_RX && rd_dr_i))) begin
						byte_done_flag_o <= 1'b0;
						transmit_flag_o  <= 1'b0;
						sr1_seen         <= 1'b0;
						state            <= S_STOP;
						phase            <= 2'h0;
					end else begin
						case (hold)
						H_SB: begin
							// Address goes out only after read then write.
							if (sr1_seen && wr_dr_i) begin
								start_sent_flag_o <= 1'b0;
								shift   <= wr_data_i;
								is_addr <= 1'b1;
								// A header with lsb clear asks for a second byte;
								// otherwise one byte and its lsb is the direction.
								is_hdr  <= hdr_wr & ~wr_data_i[0];
								rx_dir  <= wr_data_i[0];
								state   <= S_BIT;
							end
						end
						H_HEADER_SENT_FLAG: begin
							if (sr1_seen && wr_dr_i) begin
								header_sent_flag_o <= 1'b0;
								shift  <= wr_data_i;
								is_hdr <= 1'b0;
								state  <= S_BIT;
							end
						end
						H_ADDR: begin
							// Control write after status read clears the address event; reads go on at once, writes then wait for data.
							if (sr1_seen && wr_cr_i) begin
								addr_done <= 1'b0;
								is_addr   <= 1'b0;
								if (rx_dir) begin
									sr1_seen <= 1'b0;
									state    <= S_BIT;
								end else begin
									hold <= H_TX;
								end
							end
						end
						H_TX: begin
							if (sr1_seen && wr_dr_i) begin
								byte_done_flag_o <= 1'b0;
								transmit_flag_o  <= 1'b0;
								shift            <= wr_data_i;
								state            <= S_BIT;
							end
						end
						default: begin
							if (sr1_seen && rd_dr_i) begin
								byte_done_flag_o <= 1'b0;
								state            <= S_BIT;
							end
						end
						endcase
					end
					if (state != S_HOLD || phase != 2'h0) begin
						phase   <= 2'h0;
						bit_idx <= 4'h0;
					end
					if (hold == H_SB || !sr1_seen || wr_dr_i || rd_dr_i ||
					    wr_cr_i) begin
						bit_idx <= 4'h0;
					end
				end

				S_BIT: begin
					if (sr1_seen)
						sr1_seen <= 1'b0;
					if (step) begin
						phase <= phase + 2'h1;
						case (phase)
						2'h0: begin
							// Set SDA while SCL is low.
							if (ack_slot)
								sda_drv <= rx_byte & ack_enable_i;
							else
								sda_drv <= ~rx_byte & ~shift[7];
						end
						2'h1: begin
							scl_drv <= 1'b0;
						end
						2'h2: begin
							scl_drv <= 1'b0;
						end
						default: begin
							scl_drv <= 1'b1;
							bit_idx <= bit_idx + 4'h1;
							if (!ack_slot) begin
								shift <= {shift[6:0], sda_s};
								// Sent a one but the line reads zero.
								if (!rx_byte && shift[7] && !sda_s) begin
									arb_lost_flag_o      <= 1'b1;
									master_select_flag_o <= 1'b0;
									scl_drv              <= 1'b0;
									sda_drv              <= 1'b0;
									state                <= S_IDLE;
								end
							end else begin
								bit_idx <= 4'h0;
								if (rx_byte) begin
									data_o           <= shift;
									byte_done_flag_o <= 1'b1;
									hold             <= H_RX;
									state            <= S_HOLD;
								end else if (sda_s) begin
									// No SCL stretch after a nack.
									nack_flag_o <= 1'b1;
									scl_drv     <= 1'b0;
									state       <= S_FREE;
								end else if (is_addr && is_hdr) begin
									header_sent_flag_o <= 1'b1;
									hold               <= H_HEADER_SENT_FLAG;
									state              <= S_HOLD;
								end else if (is_addr) begin
									addr_done <= 1'b1;
									hold      <= H_ADDR;
									state     <= S_HOLD;
								end else if (stop_req_o) begin
									state <= S_STOP;
								end else begin
									byte_done_flag_o <= 1'b1;
									transmit_flag_o  <= 1'b1;
									hold             <= H_TX;
									state            <= S_HOLD;
								end
							end
						end
						endcase
					end
					// Early status two read: the nack stays set through
					// the high part of the ninth clock.
					if (ack_slot && !rx_byte && phase == 2'h3 && scl_s &&
					    sda_s) begin
						nack_flag_o <= 1'b1;
					end
					// Misplaced conditions inside a byte.
					if (start_det || stop_det) begin
						if (bit_idx < `I2C_BUS_ERROR_FLAG_IDX) begin
							busy_flag_o <= 1'b0;
						end else begin
							bus_error_flag_o <= 1'b1;
							busy_flag_o      <= 1'b0;
							scl_drv          <= 1'b0;
							state            <= S_FREE;
						end
					end
				end

				S_STOP: begin
					if (step) begin
						phase <= phase + 2'h1;
						case (phase)
						2'h0: begin
							scl_drv <= 1'b1;
							sda_drv <= 1'b1;
						end
						2'h1: begin
							scl_drv <= 1'b0;
						end
						2'h2: begin
							sda_drv <= 1'b0;
						end
						default: begin
							// Stop placed: drop the request and mastership.
							stop_req_o           <= 1'b0;
							master_select_flag_o <= 1'b0;
							state                <= S_IDLE;
						end
						endcase
					end
				end

				S_FREE: begin
					// SCL left free; SDA keeps its last level until the
					// software asks for a start or a stop.
					scl_drv <= 1'b0;
					if (start_req_o) begin
						sda_drv <= 1'b0;
						state   <= S_START;
						phase   <= 2'h0;
					end else if (stop_req_o) begin
						state <= S_STOP;
						phase <= 2'h0;
					end
				end

				default: begin
					state <= S_IDLE;
				end
				endcase
			end
		end
	end

endmodule // i2c_master_sequencer

// ### i2c_seq_map.vh
/*
 * Constants for the I2C master sequencer: bit timing, address header
 * pattern and counter widths.
 * Assumes the system clock runs at 50 MHz and that every file which
 * needs these names includes this header by its bare name.
 */
`ifndef I2C_SEQ_MAP_VH
`define I2C_SEQ_MAP_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// System clock period in ns.
`define I2C_CLK_NS        20
// Quarter bit time in ns, standard mode (100 kHz) and fast mode (400 kHz).
`define I2C_QTR_STD_NS    2500
`define I2C_QTR_FAST_NS   625
// Quarter bit times in clock cycles; least times round up.
`define I2C_QTR_STD_CYC   ((`I2C_QTR_STD_NS + `I2C_CLK_NS - 1) / `I2C_CLK_NS)
`define I2C_QTR_FAST_CYC  ((`I2C_QTR_FAST_NS + `I2C_CLK_NS - 1) / `I2C_CLK_NS)
// Width of the quarter bit counter.
`define I2C_QTR_W         8

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
// Upper five bits of a 10-bit address header byte.
`define I2C_HDR_PATTERN   5'h1E
// Index of the acknowledge slot within a nine clock transaction.
`define I2C_ACK_IDX       4'h8
// First bit index at which a misplaced condition counts as bus error.
`define I2C_BUS_ERROR_FLAG_IDX      4'h2

`endif

// ### i2c_line_monitor.v
/*
 * Bus line monitor: synchronises SCL and SDA to the system clock and
 * finds Start and Stop conditions on the bus.
 * Assumes the pins are asynchronous to sys_clk_i and much slower.
 */
`timescale 1ns/100ps

module i2c_line_monitor (
	input  wire sys_clk_i,
	input  wire rst_i,
	input  wire en_i,
	input  wire scl_i,
	input  wire sda_i,
	output reg  scl_o,
	output reg  sda_o,
	output wire start_det_o,
	output wire stop_det_o
);

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	reg scl_m;
	reg sda_m;
	reg sda_d;

	// Two flops per pin; the first flop feeds only the second.
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			scl_m <= 1'b1;
			sda_m <= 1'b1;
			scl_o <= 1'b1;
			sda_o <= 1'b1;
			sda_d <= 1'b1;
		end else if (en_i) begin
			scl_m <= scl_i;
			sda_m <= sda_i;
			scl_o <= scl_m;
			sda_o <= sda_m;
			sda_d <= sda_o;
		end
	end

	// ------------------------------------------------------------------
	// Condition detect
	// ------------------------------------------------------------------
	// SDA moving while SCL stays high marks a Start or a Stop.
	assign start_det_o = en_i & scl_o & sda_d & ~sda_o;
	assign stop_det_o  = en_i & scl_o & ~sda_d & sda_o;

endmodule // i2c_line_monitor

// ### i2c_bit_timer.v
/*
 * Quarter bit timer: emits one tick per quarter of an SCL period.
 * Assumes restart_i is held while the sequencer needs no timing.
 */
`timescale 1ns/100ps
`include "i2c_seq_map.vh"

module i2c_bit_timer (
	input  wire sys_clk_i,
	input  wire rst_i,
	input  wire en_i,
	input  wire restart_i,
	input  wire fast_i,
	output wire tick_o
);

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	// Counts are worked out as integers and cut to the counter width.
	localparam integer          STD_END   = `I2C_QTR_STD_CYC - 1;
	localparam integer          FAST_END  = `I2C_QTR_FAST_CYC - 1;
	localparam [`I2C_QTR_W-1:0] STD_LAST  = STD_END[`I2C_QTR_W-1:0];
	localparam [`I2C_QTR_W-1:0] FAST_LAST = FAST_END[`I2C_QTR_W-1:0];

	reg  [`I2C_QTR_W-1:0] count;
	wire [`I2C_QTR_W-1:0] last;

	assign last   = fast_i ? FAST_LAST : STD_LAST;
	assign tick_o = en_i & ~restart_i & (count == last);

	// Free running between restarts so each quarter has equal length.
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			count <= {`I2C_QTR_W{1'b0}};
		end else if (en_i) begin
			if (restart_i || count == last)
				count <= {`I2C_QTR_W{1'b0}};
			else
				count <= count + 1'b1;
		end
	end

endmodule // i2c_bit_timer

// ### i2c_seq_monitor.sv
/* Checker on the ports of the I2C master sequencer.
   Assumes it is bound to the sequencer; reset is synchronous. */
`timescale 1ns/100ps
module i2c_seq_monitor (
	input wire       sys_clk_i, rst_i, ce_i, halt_i, global_mask_i,
	input wire       periph_enable_i, irq_enable_i, start_set_i, wr_dr_i,
	input wire       scl_oe_n_o, sda_oe_n_o, event_flag_o, irq_o,
	input wire [7:0] data_o,
	input wire       byte_done_flag_o, busy_flag_o, master_select_flag_o,
	input wire       start_sent_flag_o, nack_flag_o, arb_lost_flag_o,
	input wire       bus_error_flag_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// A start request is taken only while running and the bus is idle.
	sequence s_start_req;
		start_set_i && !busy_flag_o && ce_i && !halt_i && periph_enable_i;
	endsequence
	// Two cycles of a pending flag give the pull-down time to land.
	sequence s_held;
		(start_sent_flag_o || byte_done_flag_o) [*2];
	endsequence
	a_start_master: assert property (
		s_start_req |-> ##2 master_select_flag_o) else $error("no master");
	a_scl_held: assert property (
		s_held |-> halt_i || !scl_oe_n_o) else $error("scl not held");
	a_sb_clear: assert property (
		$fell(start_sent_flag_o) && $past(periph_enable_i) |-> $past(wr_dr_i))
		else $error("start event cleared early");
	a_error_event: assert property (
		nack_flag_o || arb_lost_flag_o || bus_error_flag_o |-> event_flag_o)
		else $error("error without event");
	a_arb_drop: assert property (
		$rose(arb_lost_flag_o) |-> !master_select_flag_o)
		else $error("master kept");
	a_halt_release: assert property (
		halt_i |-> scl_oe_n_o && sda_oe_n_o) else $error("lines held");
	a_halt_freeze: assert property (
		halt_i |=> $stable(data_o) && $stable(master_select_flag_o))
		else $error("state moved in halt");
	a_irq_gate: assert property (
		irq_o == (event_flag_o && irq_enable_i && !global_mask_i))
		else $error("irq wrong");
endmodule // i2c_seq_monitor
bind i2c_master_sequencer i2c_seq_monitor i_i2c_seq_monitor (.*);

// ### i2c_slave_model.sv
/* Behavioural I2C slave on the far side of the pins.
   Assumes the bench resolves the open-drain wires. */
`timescale 1ns/100ps
module i2c_slave_model (
	input  wire       scl_i,
	input  wire       sda_i,
	input  wire [7:0] tx_i,
	output reg        sda_pull_o
);
	reg [3:0] cnt = 4'h8;
	reg [7:0] sh = 8'h00;
	reg       rd = 1'b0;
	reg       adr = 1'b0;
	initial sda_pull_o = 1'b0;
	// Start marks an address byte next; Stop lets the line go.
	always @(sda_i) if (scl_i) begin
		cnt = 4'h8;
		adr = !sda_i;
		rd = 1'b0;
		sda_pull_o = 1'b0;
	end
	// Bits are taken MSB first; a high ack slot ends a read.
	always @(posedge scl_i)
		if (cnt < 4'h8) sh = {sh[6:0], sda_i};
		else if (sda_i) rd = 1'b0;
	// Data moves only while SCL is low, so no false Start or Stop.
	always @(negedge scl_i) begin
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
		if (cnt == 4'h8 && adr) rd = sh[0];
		sda_pull_o = (cnt == 4'h8) ? !rd || adr : rd && !tx_i[3'h7 - cnt[2:0]];
		if (cnt == 4'h8) adr = 1'b0;
	end
endmodule // i2c_slave_model

// ### tb.sv
/* Bench: a write, a read and a ten bit transfer to a slave model.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
module tb;
	reg        clk = 1'b0, rst = 1'b1, halt = 1'b0, mask = 1'b1;
	reg        ack_en = 1'b1, irq_en = 1'b1, bd_q = 1'b0;
	reg  [7:0] str = 8'h00, wdat = 8'h00, tx = 8'h00;
	reg  [7:0] exp_q [$];
	integer    seed = 76711, r, i, j, fail_count = 0, check_count = 0;
	wire       scl_oe_n, sda_oe_n, pull, ev, bd, tra, ms, sb, sp;
	wire [7:0] dat;
	wire       scl = scl_oe_n;
	wire       sda = sda_oe_n && !pull;
	wire [3:0] st = {!ms, sb, bd, ev};
	always #10 clk = !clk;
	i2c_master_sequencer i_i2c_master_sequencer (
		.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .halt_i(halt),
		.global_mask_i(mask), .periph_enable_i(1'b1), .ack_enable_i(ack_en),
		.irq_enable_i(irq_en), .fast_mode_i(1'b1), .start_set_i(str[7]),
		.stop_set_i(str[6]), .stop_clr_i(str[5]), .rd_sr1_i(str[4]),
		.rd_sr2_i(str[3]), .rd_dr_i(str[2]), .wr_dr_i(str[1]),
		.wr_cr_i(str[0]), .wr_data_i(wdat), .scl_i(scl), .sda_i(sda),
		.scl_o(), .scl_oe_n_o(scl_oe_n), .sda_o(), .sda_oe_n_o(sda_oe_n),
		.data_o(dat), .start_req_o(), .stop_req_o(sp), .event_flag_o(ev),
		.header_sent_flag_o(), .byte_done_flag_o(bd), .transmit_flag_o(tra),
		.busy_flag_o(), .master_select_flag_o(ms), .start_sent_flag_o(sb),
		.nack_flag_o(), .stop_seen_flag_o(), .arb_lost_flag_o(),
		.bus_error_flag_o(), .irq_o());
	i2c_slave_model i_i2c_slave_model (.scl_i(scl), .sda_i(sda),
		.tx_i(tx), .sda_pull_o(pull));
	task chk(input [7:0] seen, input [7:0] want);
		check_count = check_count + 1;
		if (seen !== want) begin
			fail_count = fail_count + 1;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	// Strobe for one cycle; the gap cycle keeps strobes apart.
	task acc(input [7:0] m, input [7:0] d);
		@(negedge clk) begin str = m; wdat = d; end
		@(negedge clk) str = 8'h00;
	endtask
	task wt(input integer k);
		for (i = 0; i < 9000 && st[k] !== 1'b1; i = i + 1) @(negedge clk);
		if (st[k] !== 1'b1) fail_count = fail_count + 1;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Each received byte is compared with the oldest noted value.
	always @(negedge clk) begin
		if (bd && !bd_q && !tra) chk(dat, exp_q.pop_front());
		bd_q <= bd;
	end
	// The run needs under 15000 cycles; this cuts a hang short.
	initial begin
		repeat (40000) @(posedge clk);
		fail_count = fail_count + 1;
		tally_and_finish;
	end
	// Write two random bytes, idle in halt, then read two bytes.
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		acc(8'h80, 8'h00);
		@(negedge clk);
		chk(ms, 1'b1);
		wt(2);
		acc(8'h10, 8'h00);
		acc(8'h02, 8'h54);
		chk(sb, 1'b0);
		wt(0);
		acc(8'h10, 8'h00);
		acc(8'h01, 8'h00);
		chk(ev, 1'b0);
		for (j = 0; j < 2; j = j + 1) begin
			r = $random(seed);
			acc(8'h02, r[7:0]);
			if (j == 0) begin
				wt(1);
				chk(tra, 1'b1);
				acc(8'h10, 8'h00);
			end
		end
		acc(8'h40, 8'h00);
		wt(3);
		chk(sp, 1'b0);
		$display("write test done");
		halt = 1'b1;
		mask = 1'b0;
		repeat (20) @(negedge clk);
		halt = 1'b0;
		r = $random(seed);
		tx = r[7:0];
		acc(8'h80, 8'h00);
		wt(2);
		acc(8'h10, 8'h00);
		acc(8'h02, 8'h55);
		wt(0);
		acc(8'h10, 8'h00);
		acc(8'h01, 8'h00);
		for (j = 0; j < 2; j = j + 1) begin
			exp_q.push_back(tx);
			wt(1);
			acc(8'h10, 8'h00);
			if (j == 1) acc(8'h40, 8'h00);
			else ack_en = 1'b0;
			acc(8'h04, 8'h00);
		end
		wt(3);
		chk(ms, 1'b0);
		$display("read test done");
		// Ten bit header, second byte, then repeated start to read.
		r = $random(seed);
		tx = r[7:0];
		acc(8'h80, 8'h00);
		wt(2);
		acc(8'h10, 8'h00);
		acc(8'h02, 8'hF0);
		wt(0);
		acc(8'h10, 8'h00);
		acc(8'h02, 8'h3C);
		wt(0);
		acc(8'h10, 8'h00);
		ack_en = 1'b0;
		acc(8'h81, 8'h00);
		wt(2);
		acc(8'h10, 8'h00);
		acc(8'h02, 8'hF1);
		wt(0);
		acc(8'h10, 8'h00);
		exp_q.push_back(tx);
		acc(8'h01, 8'h00);
		wt(1);
		acc(8'h10, 8'h00);
		acc(8'h40, 8'h00);
		acc(8'h04, 8'h00);
		wt(3);
		chk(ms, 1'b0);
		$display("ten bit test done");
		tally_and_finish;
	end
endmodule // tb
